/* File: core/csr_pkg.sv */
/*
 * Package for the core special-function block: register offsets, field
 * positions, reset values, command codes and carrier structs.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package csr_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CSR_OFF_STATUS = 8'h00;
	localparam logic [7:0] CSR_OFF_CONFIG = 8'h04;
	localparam logic [7:0] CSR_OFF_POWER = 8'h08;
	localparam logic [7:0] CSR_OFF_PC_LOW = 8'h0c;
	localparam logic [7:0] CSR_OFF_PC_LATCH = 8'h10;
	localparam logic [7:0] CSR_OFF_PULLUP_MASK = 8'h14;
	localparam logic [7:0] CSR_OFF_INDIRECT_PTR = 8'h18;
	localparam logic [7:0] CSR_OFF_CORE_CMD = 8'h1c;
	localparam logic [7:0] CSR_OFF_ALU_RESULT = 8'h20;
	localparam logic [7:0] CSR_OFF_PC_VIEW = 8'h24;
	localparam logic [7:0] CSR_OFF_BOOT_CAUSE = 8'h28;

	// ------------------------------------------------------------
	// status field positions
	// ------------------------------------------------------------
	localparam int CSR_ST_IND_BANK = 7;
	localparam int CSR_ST_DBANK_HI = 6;
	localparam int CSR_ST_DBANK_LO = 5;
	localparam int CSR_ST_WDOG_EXP = 4;
	localparam int CSR_ST_SLEEP = 3;
	localparam int CSR_ST_ZERO = 2;
	localparam int CSR_ST_NIBBLE = 1;
	localparam int CSR_ST_CARRY = 0;

	// ------------------------------------------------------------
	// config field positions
	// ------------------------------------------------------------
	localparam int CSR_CF_PULLUP_DIS = 7;
	localparam int CSR_CF_IRQ_EDGE = 6;
	localparam int CSR_CF_TMR_SRC = 5;
	localparam int CSR_CF_TMR_EDGE = 4;
	localparam int CSR_CF_PRE_TGT = 3;
	localparam int CSR_CF_RATIO_HI = 2;

	// ------------------------------------------------------------
	// power control field positions
	// ------------------------------------------------------------
	localparam int CSR_PW_POR = 1;
	localparam int CSR_PW_BOR = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] CSR_STATUS_RST = 8'h18;
	localparam logic [7:0] CSR_CONFIG_RST = 8'hff;
	localparam logic [1:0] CSR_POWER_POR_VAL = 2'h1;
	localparam logic [1:0] CSR_BOR_SOFT_CODE = 2'h1;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int CSR_PC_W = 13;
	localparam int CSR_STACK_DEPTH = 8;
	localparam int CSR_SP_W = 3;

	// ------------------------------------------------------------
	// core command codes (low nibble of command register)
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CSR_CMD_NOP = 4'h0,
		CSR_CMD_ADD = 4'h1,
		CSR_CMD_SUB = 4'h2,
		CSR_CMD_LOGIC = 4'h3,
		CSR_CMD_ROT_LEFT = 4'h4,
		CSR_CMD_ROT_RIGHT = 4'h5,
		CSR_CMD_CALL = 4'h6,
		CSR_CMD_JUMP = 4'h7,
		CSR_CMD_RETURN = 4'h8,
		CSR_CMD_IRQ_VEC = 4'h9,
		CSR_CMD_KICK = 4'ha,
		CSR_CMD_SLEEP = 4'hb,
		CSR_CMD_WDOG_TIMEOUT = 4'hc,
		CSR_CMD_BROWNOUT = 4'hd
	} csr_cmd_e;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic [31:0] wdata;
	} csr_req_s;

	typedef struct packed {
		logic pullup_disable;
		logic [7:0] pullup_enable;
		logic irq_rising;
		logic tmr_from_pin;
		logic tmr_falling;
		logic pre_to_wdog;
		logic [8:0] tmr_div;
		logic [7:0] wdog_div;
	} csr_timer_cfg_s;

	typedef struct packed {
		logic [8:0] direct_base;
		logic [8:0] indirect_addr;
	} csr_addr_s;

	typedef struct packed {
		logic [7:0] status_r;
		logic [7:0] config_r;
		logic [1:0] power_r;
		logic [CSR_PC_W-1:0] pc_r;
		logic [4:0] latch_r;
		logic [7:0] pullup_mask_r;
		logic [7:0] ind_ptr_r;
		logic [7:0] alu_r;
		logic [CSR_SP_W-1:0] sp_r;
		logic [CSR_STACK_DEPTH-1:0][CSR_PC_W-1:0] stack_r;
		logic pready_r;
		logic pslverr_r;
		logic [31:0] prdata_r;
		csr_timer_cfg_s tcfg_r;
		csr_addr_s addr_r;
		logic bor_enable_r;
	} csr_state_s;

endpackage

/* File: core/csr_core.sv */
/*
 * Core special-function block: status flags, core configuration, power
 * control flags, 13-bit program counter with 5-bit high latch and the
 * 8-level circular return stack, all behind an APB slave.
 * Assumes pclk is the instruction-cycle clock and presetn is the
 * power-on reset; a brownout or other event arrives as a command.
 */
// Notes on behaviour
// - ALU writing status keeps its own zero, nibble and carry flags.
// - watchdog-expiry and sleep-entered flags ignore register writes.
// - indirect bank bit 7 picks banks 2-3 when set, 0-1 when clear.
// - direct bank bits 6-5 select bank 0 to 3 directly.
// - expiry flag set on power-up, kick, sleep; cleared by watchdog timeout.
// - sleep flag set on power-up and kick; cleared by sleep.
// - zero flag set when result is zero, else cleared.
// - nibble flag is carry out of bit 3; inverted borrow on subtract.
// - carry flag is carry out of msb; no-borrow; rotate loads shifted bit.
// - pull-up disable bit kills all pull-ups, else mask bits apply.
// - irq edge bit picks rising when set, falling when clear.
// - timer source bit picks pin transitions or instruction clock.
// - timer edge bit picks falling pin edges when set.
// - prescaler target bit gives prescaler to watchdog when set.
// - timer divide is 2 shl ratio; watchdog divide is 1 shl ratio.
// - power-on reset clears power-on flag; software sets it again.
// - brownout clears brownout flag; power bits 7-2 read zero.
// - brownout flag enables brownout detect only when config is 01.
// - 13-bit pc, low byte accessible, every reset clears it.
// - pc low write loads latch 4:0 above; call/jump use latch 4:3.
// - 8-deep 13-bit stack; push on call/irq, pop on returns.
// - stack is circular; no overflow or underflow flag exists.
// - indirect address is bank bit over the 8-bit pointer.
`timescale 1ns/1ns

module csr_core
	import csr_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// device configuration
	input wire logic [1:0] brownout_soft_control_config,
	// derived controls
	output csr_timer_cfg_s timer_cfg,
	output csr_addr_s data_addr,
	output logic brownout_detect_en,
	output logic [CSR_PC_W-1:0] program_counter
);

	csr_state_s s_r;
	csr_state_s s_nxt;

	logic access;
	logic wr;
	logic [7:0] a;
	logic [7:0] wb;
	logic [3:0] cmd;
	logic [7:0] op_a;
	logic [7:0] op_b;
	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] res;
	logic [2:0] ratio;

	assign access = psel && penable && !s_r.pready_r;
	assign wr = access && pwrite && pstrb[0];
	assign a = paddr[7:0];
	assign wb = pwdata[7:0];
	assign cmd = pwdata[3:0];
	assign op_a = pwdata[15:8];
	assign op_b = pwdata[23:16];

	always_comb begin
		s_nxt = s_r;
		sum = 9'h000;
		nib = 5'h00;
		res = 8'h00;
		ratio = s_r.config_r[CSR_CF_RATIO_HI:0];
		s_nxt.pready_r = access;
		s_nxt.pslverr_r = 1'b0;
		s_nxt.prdata_r = 32'h0000_0000;

		// ------------------------------------------------------------
		// register reads
		// ------------------------------------------------------------
		if (access && !pwrite) begin
			case (a)
			CSR_OFF_STATUS: s_nxt.prdata_r[7:0] = s_r.status_r;
			CSR_OFF_CONFIG: s_nxt.prdata_r[7:0] = s_r.config_r;
			CSR_OFF_POWER: s_nxt.prdata_r[1:0] = s_r.power_r;
			CSR_OFF_PC_LOW: s_nxt.prdata_r[7:0] = s_r.pc_r[7:0];
			CSR_OFF_PC_LATCH: s_nxt.prdata_r[4:0] = s_r.latch_r;
			CSR_OFF_PULLUP_MASK: s_nxt.prdata_r[7:0] = s_r.pullup_mask_r;
			CSR_OFF_INDIRECT_PTR: s_nxt.prdata_r[7:0] = s_r.ind_ptr_r;
			CSR_OFF_CORE_CMD: s_nxt.prdata_r = 32'h0000_0000;
			CSR_OFF_ALU_RESULT: s_nxt.prdata_r[7:0] = s_r.alu_r;
			CSR_OFF_PC_VIEW: s_nxt.prdata_r[CSR_PC_W-1:0] = s_r.pc_r;
			default: s_nxt.pslverr_r = 1'b1;
			endcase
		end

		// ------------------------------------------------------------
		// register writes
		// ------------------------------------------------------------
		if (access && pwrite) begin
			case (a)
			CSR_OFF_STATUS: begin
				if (wr) begin
					// expiry and sleep flags keep their value
					s_nxt.status_r[7:5] = wb[7:5];
					s_nxt.status_r[2:0] = wb[2:0];
				end
			end
			CSR_OFF_CONFIG: if (wr) s_nxt.config_r = wb;
			CSR_OFF_POWER: begin
				if (wr) s_nxt.power_r = wb[1:0];
			end
			CSR_OFF_PC_LOW: begin
				if (wr) s_nxt.pc_r = {s_r.latch_r, wb};
			end
			CSR_OFF_PC_LATCH: if (wr) s_nxt.latch_r = wb[4:0];
			CSR_OFF_PULLUP_MASK: if (wr) s_nxt.pullup_mask_r = wb;
			CSR_OFF_INDIRECT_PTR: if (wr) s_nxt.ind_ptr_r = wb;
			CSR_OFF_CORE_CMD: begin
				if (wr) begin
					case (cmd)
					CSR_CMD_ADD, CSR_CMD_SUB: begin
						if (cmd == CSR_CMD_SUB) begin
							// add two's complement of second operand
							sum = {1'b0, op_a} + {1'b0, ~op_b} + 9'h001;
							nib = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]}
								+ 5'h01;
						end else begin
							sum = {1'b0, op_a} + {1'b0, op_b};
							nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
						end
						res = sum[7:0];
						s_nxt.status_r[CSR_ST_CARRY] = sum[8];
						s_nxt.status_r[CSR_ST_NIBBLE] = nib[4];
						s_nxt.status_r[CSR_ST_ZERO] = (res == 8'h00);
						s_nxt.alu_r = res;
					end
					CSR_CMD_LOGIC: begin
						res = op_a & op_b;
						s_nxt.status_r[CSR_ST_ZERO] = (res == 8'h00);
						s_nxt.alu_r = res;
					end
					CSR_CMD_ROT_LEFT: begin
						s_nxt.alu_r = {op_a[6:0], s_r.status_r[CSR_ST_CARRY]};
						s_nxt.status_r[CSR_ST_CARRY] = op_a[7];
					end
					CSR_CMD_ROT_RIGHT: begin
						s_nxt.alu_r = {s_r.status_r[CSR_ST_CARRY], op_a[7:1]};
						s_nxt.status_r[CSR_ST_CARRY] = op_a[0];
					end
					CSR_CMD_CALL, CSR_CMD_IRQ_VEC: begin
						// push return address; oldest entry overwritten
						s_nxt.stack_r[s_r.sp_r] = s_r.pc_r;
						s_nxt.sp_r = s_r.sp_r + 3'h1;
						if (cmd == CSR_CMD_CALL) begin
							s_nxt.pc_r = {s_r.latch_r[4:3],
								pwdata[26:16]};
						end else begin
							s_nxt.pc_r = pwdata[28:16];
						end
					end
					CSR_CMD_JUMP: begin
						s_nxt.pc_r = {s_r.latch_r[4:3], pwdata[26:16]};
					end
					CSR_CMD_RETURN: begin
						// pop wraps freely; latch untouched
						s_nxt.sp_r = s_r.sp_r - 3'h1;
						s_nxt.pc_r = s_r.stack_r[s_r.sp_r - 3'h1];
					end
					CSR_CMD_KICK: begin
						s_nxt.status_r[CSR_ST_WDOG_EXP] = 1'b1;
						s_nxt.status_r[CSR_ST_SLEEP] = 1'b1;
					end
					CSR_CMD_SLEEP: begin
						s_nxt.status_r[CSR_ST_WDOG_EXP] = 1'b1;
						s_nxt.status_r[CSR_ST_SLEEP] = 1'b0;
					end
					CSR_CMD_WDOG_TIMEOUT: begin
						s_nxt.status_r[CSR_ST_WDOG_EXP] = 1'b0;
						s_nxt.pc_r = '0;
					end
					CSR_CMD_BROWNOUT: begin
						s_nxt.power_r[CSR_PW_BOR] = 1'b0;
						s_nxt.status_r[CSR_ST_WDOG_EXP] = 1'b1;
						s_nxt.status_r[CSR_ST_SLEEP] = 1'b1;
						s_nxt.status_r[7:5] = 3'h0;
						s_nxt.pc_r = '0;
					end
					default: s_nxt.alu_r = s_r.alu_r;
					endcase
				end
			end
			default: s_nxt.pslverr_r = 1'b1;
			endcase
		end

		// ------------------------------------------------------------
		// derived controls
		// ------------------------------------------------------------
		// status as destination of a flag-writing op: the op wins
		s_nxt.tcfg_r.pullup_disable = s_nxt.config_r[CSR_CF_PULLUP_DIS];
		s_nxt.tcfg_r.pullup_enable = s_nxt.config_r[CSR_CF_PULLUP_DIS] ?
			8'h00 : s_nxt.pullup_mask_r;
		s_nxt.tcfg_r.irq_rising = s_nxt.config_r[CSR_CF_IRQ_EDGE];
		s_nxt.tcfg_r.tmr_from_pin = s_nxt.config_r[CSR_CF_TMR_SRC];
		s_nxt.tcfg_r.tmr_falling = s_nxt.config_r[CSR_CF_TMR_EDGE];
		s_nxt.tcfg_r.pre_to_wdog = s_nxt.config_r[CSR_CF_PRE_TGT];
		ratio = s_nxt.config_r[CSR_CF_RATIO_HI:0];
		if (s_nxt.config_r[CSR_CF_PRE_TGT]) begin
			s_nxt.tcfg_r.tmr_div = 9'h001;
			s_nxt.tcfg_r.wdog_div = 8'h01 << ratio;
		end else begin
			s_nxt.tcfg_r.tmr_div = 9'h002 << ratio;
			s_nxt.tcfg_r.wdog_div = 8'h01;
		end
		s_nxt.addr_r.indirect_addr = {s_nxt.status_r[CSR_ST_IND_BANK],
			s_nxt.ind_ptr_r};
		s_nxt.addr_r.direct_base = {s_nxt.status_r[CSR_ST_DBANK_HI:
			CSR_ST_DBANK_LO], 7'h00};
		s_nxt.bor_enable_r = (brownout_soft_control_config ==
			CSR_BOR_SOFT_CODE) && s_nxt.power_r[CSR_PW_BOR];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.status_r <= CSR_STATUS_RST;
			s_r.config_r <= CSR_CONFIG_RST;
			s_r.power_r <= CSR_POWER_POR_VAL;
			s_r.tcfg_r.pullup_disable <= 1'b1;
			s_r.tcfg_r.irq_rising <= 1'b1;
			s_r.tcfg_r.tmr_from_pin <= 1'b1;
			s_r.tcfg_r.tmr_falling <= 1'b1;
			s_r.tcfg_r.pre_to_wdog <= 1'b1;
			s_r.tcfg_r.tmr_div <= 9'h001;
			s_r.tcfg_r.wdog_div <= 8'h80;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata_r;
	assign pready = s_r.pready_r;
	assign pslverr = s_r.pslverr_r;
	assign timer_cfg = s_r.tcfg_r;
	assign data_addr = s_r.addr_r;
	assign brownout_detect_en = s_r.bor_enable_r;
	assign program_counter = s_r.pc_r;

endmodule

/* File: tb/csr_core_asserts.sv */
/* port checker for csr_core.
   assumes bind onto csr_core, one clock, async active-low reset. */
`timescale 1ns/1ns
module csr_core_asserts
	import csr_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// config and derived
	input wire logic [1:0] brownout_soft_control_config,
	input wire csr_timer_cfg_s timer_cfg,
	input wire csr_addr_s data_addr,
	input wire logic brownout_detect_en,
	input wire logic [CSR_PC_W-1:0] program_counter
);
	// ----------------
	// properties
	// ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && !pready;
	wire pcw = pready && pwrite && paddr[7:0] == CSR_OFF_PC_LOW && pstrb[0];
	wire prd = pready && !pwrite && paddr[7:0] == CSR_OFF_POWER;
	wire srd = pready && !pwrite && paddr[7:0] == CSR_OFF_STATUS;

	chk_one_wait: assert property (acc |=> pready)
		else $error("pready missing");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_power_zero: assert property (prd |-> prdata[31:2] == 30'h0)
		else $error("power top bits set");
	chk_pullup_off: assert property (timer_cfg.pullup_disable |->
		timer_cfg.pullup_enable == 8'h0)
		else $error("pull-ups on");
	chk_timer_div: assert property (!timer_cfg.pre_to_wdog |->
		timer_cfg.wdog_div == 8'h1 && !timer_cfg.tmr_div[0] &&
		$onehot(timer_cfg.tmr_div[8:1]))
		else $error("timer divide bad");
	chk_wdog_div: assert property (timer_cfg.pre_to_wdog |->
		timer_cfg.tmr_div == 9'h1 && $onehot(timer_cfg.wdog_div))
		else $error("watchdog divide bad");
	chk_bor_gate: assert property (brownout_detect_en |->
		$past(brownout_soft_control_config) == CSR_BOR_SOFT_CODE)
		else $error("brownout enable bad");
	chk_bank_base: assert property (data_addr.direct_base[6:0] == 7'h0)
		else $error("bank base bad");
	chk_bank_match: assert property (srd |->
		data_addr.direct_base[8:7] == prdata[6:5] &&
		data_addr.indirect_addr[8] == prdata[7])
		else $error("bank select mismatch");
	chk_pc_reset: assert property ($rose(presetn) |->
		program_counter == 13'h0)
		else $error("pc not cleared");
	chk_pc_low: assert property (pcw |=>
		program_counter[7:0] == $past(pwdata[7:0]))
		else $error("pc low not loaded");
endmodule

bind csr_core csr_core_asserts u_csr_core_asserts(.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
	.brownout_soft_control_config, .timer_cfg, .data_addr,
	.brownout_detect_en, .program_counter);

/* File: tb/testbench.sv */
/* self-checking bench for csr_core: apb tasks, random and corner tests.
   assumes the package offsets and a one-wait-state apb slave. */
`timescale 1ns/1ns
module testbench;
	import csr_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
$display("Error at %0t: got %h want %h", $time, g, e); end end
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
	logic [3:0] pstrb = 4'hf;
	logic [1:0] bcfg = 2'h0;
	logic pready, pslverr, bden, er;
	logic [12:0] pc, epc, t;
	logic [7:0] a, b, v, m;
	logic [4:0] lat;
	logic [2:0] f, sp;
	logic [3:0] op;
	logic [10:0] e;
	logic [12:0] stk [8];
	logic [3:0] ev [5] = '{4'hb, 4'hc, 4'ha, 4'hc, 4'hb};
	logic [1:0] ex [5] = '{2'b10, 2'b00, 2'b11, 2'b01, 2'b10};
	csr_timer_cfg_s tcfg;
	csr_addr_s daddr;
	int err_count = 0, checked = 0, cyc = 0;

	csr_core u_csr_core(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr,
		.brownout_soft_control_config(bcfg), .timer_cfg(tcfg),
		.data_addr(daddr), .brownout_detect_en(bden), .program_counter(pc));

	// ----------------
	// clock, timeout, tasks
	// ----------------
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 3000) begin
			err_count++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, ad};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h0);
		`CHK(rd, x)
	endtask

	task automatic settle();
		repeat (2) @(posedge pclk);
	endtask

	function automatic csr_timer_cfg_s tc_exp(input logic [7:0] c, k);
		csr_timer_cfg_s r;
		r.pullup_disable = c[7];
		r.pullup_enable = c[7] ? 8'h0 : k;
		r.irq_rising = c[6];
		r.tmr_from_pin = c[5];
		r.tmr_falling = c[4];
		r.pre_to_wdog = c[3];
		r.tmr_div = c[3] ? 9'h1 : 9'h2 << c[2:0];
		r.wdog_div = c[3] ? 8'h1 << c[2:0] : 8'h1;
		return r;
	endfunction

	// returns {zero, nibble, carry, result}
	function automatic logic [10:0] alu_exp(input logic [3:0] o,
		input logic [7:0] x, y, input logic [2:0] g);
		logic [7:0] q;
		logic [8:0] s;
		logic [4:0] n;
		q = o == 4'h2 ? ~y : y;
		s = {1'b0, x} + {1'b0, q} + {8'h0, o == 4'h2};
		n = {1'b0, x[3:0]} + {1'b0, q[3:0]} + {4'h0, o == 4'h2};
		case (o)
		4'h3: return {(x & y) == 8'h0, g[1:0], x & y};
		4'h4: return {g[2:1], x[7], x[6:0], g[0]};
		4'h5: return {g[2:1], x[0], g[0], x[7:1]};
		default: return {s[7:0] == 8'h0, n[4], s[8], s[7:0]};
		endcase
	endfunction

	// ----------------
	// tests
	// ----------------
	initial begin
		void'($urandom(32'h7fcc35f1));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rdc(CSR_OFF_STATUS, 32'h18);
		rdc(CSR_OFF_CONFIG, 32'hff);
		rdc(CSR_OFF_POWER, 32'h1);
		rdc(CSR_OFF_PC_VIEW, 32'h0);
		`CHK(tcfg, tc_exp(8'hff, 8'h0))
		`CHK(bden, 1'b0)
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom);
			m = 8'($urandom);
			apb(1'b1, CSR_OFF_STATUS, {24'h0, v});
			apb(1'b1, CSR_OFF_INDIRECT_PTR, {24'h0, m});
			rdc(CSR_OFF_STATUS, {24'h0, v[7:5], 2'b11, v[2:0]});
			rdc(CSR_OFF_INDIRECT_PTR, {24'h0, m});
			settle();
			`CHK(daddr.direct_base, {v[6:5], 7'h0})
			`CHK(daddr.indirect_addr, {v[7], m})
		end
		$display("status test done");
		for (int i = 0; i < 12; i++) begin
			v = i == 0 ? 8'h07 : i == 1 ? 8'h0f : 8'($urandom);
			m = 8'($urandom);
			apb(1'b1, CSR_OFF_PULLUP_MASK, {24'h0, m});
			apb(1'b1, CSR_OFF_CONFIG, {24'h0, v});
			pstrb <= 4'h0;
			apb(1'b1, CSR_OFF_CONFIG, {24'h0, ~v});
			pstrb <= 4'hf;
			rdc(CSR_OFF_CONFIG, {24'h0, v});
			rdc(CSR_OFF_PULLUP_MASK, {24'h0, m});
			settle();
			`CHK(tcfg, tc_exp(v, m))
		end
		$display("config test done");
		apb(1'b1, CSR_OFF_STATUS, 32'h0);
		f = 3'h0;
		for (int i = 0; i < 20; i++) begin
			op = 4'(i % 5 + 1);
			a = i == 0 ? 8'h88 : 8'($urandom);
			b = i == 0 ? 8'h78 : i == 1 ? a : 8'($urandom);
			e = alu_exp(op, a, b, f);
			f = e[10:8];
			apb(1'b1, CSR_OFF_CORE_CMD, {8'h0, b, a, 4'h0, op});
			rdc(CSR_OFF_ALU_RESULT, {24'h0, e[7:0]});
			apb(1'b0, CSR_OFF_STATUS, 32'h0);
			`CHK(rd[2:0], f)
		end
		$display("alu test done");
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, CSR_OFF_CORE_CMD, {28'h0, ev[i]});
			apb(1'b0, CSR_OFF_STATUS, 32'h0);
			`CHK(rd[4:3], ex[i])
		end
		apb(1'b1, CSR_OFF_POWER, 32'hffffffff);
		rdc(CSR_OFF_POWER, 32'h3);
		for (int i = 0; i < 4; i++) begin
			bcfg <= 2'(i);
			settle();
			`CHK(bden, i == 1)
		end
		bcfg <= 2'h1;
		apb(1'b1, CSR_OFF_CORE_CMD, 32'hd);
		rdc(CSR_OFF_POWER, 32'h2);
		apb(1'b0, CSR_OFF_STATUS, 32'h0);
		`CHK(rd[7:3], 5'b00011)
		settle();
		`CHK(bden, 1'b0)
		$display("event test done");
		lat = 5'($urandom);
		b = 8'($urandom);
		apb(1'b1, CSR_OFF_PC_LATCH, {27'h0, lat});
		apb(1'b1, CSR_OFF_PC_LOW, {24'h0, b});
		rdc(CSR_OFF_PC_VIEW, {19'h0, lat, b});
		rdc(CSR_OFF_PC_LOW, {24'h0, b});
		epc = {lat, b};
		sp = 3'h0;
		for (int i = 0; i < 10; i++) begin
			t = 13'($urandom);
			op = i == 0 ? 4'h7 : i % 2 == 1 ? 4'h6 : 4'h9;
			apb(1'b1, CSR_OFF_CORE_CMD, op == 4'h9 ? {3'h0, t, 12'h0, op} :
				{5'h0, t[10:0], 12'h0, op});
			if (op != 4'h7) begin
				stk[sp] = epc;
				sp++;
			end
			epc = op == 4'h9 ? t : {lat[4:3], t[10:0]};
			settle();
			`CHK(pc, epc)
		end
		for (int i = 0; i < 10; i++) begin
			apb(1'b1, CSR_OFF_CORE_CMD, 32'h8);
			sp--;
			settle();
			`CHK(pc, stk[sp])
		end
		rdc(CSR_OFF_PC_LATCH, {27'h0, lat});
		apb(1'b1, CSR_OFF_PC_VIEW, 32'h0);
		`CHK(er, 1'b1)
		rdc(CSR_OFF_PC_VIEW, {19'h0, stk[sp]});
		$display("stack test done");
		apb(1'b0, 8'h40, 32'h0);
		`CHK({er, rd}, 33'h100000000)
		$display("unmapped test done");
		close_out();
	end
endmodule
